// ==== common/psc_pkg.sv ====
// shared constants and types for the processor sideband control link
package psc_pkg;
	localparam int unsigned CLK_MHZ          = 25;
	// power-on reset hold, in microseconds
	localparam int unsigned POR_HOLD_US      = 1000;
	localparam int unsigned POR_HOLD_CYC     = POR_HOLD_US * CLK_MHZ;
	// longest reset while power is stable, in microseconds
	localparam int unsigned RST_MAX_US       = 10000;
	localparam int unsigned RST_MAX_CYC      = RST_MAX_US * CLK_MHZ;
	// overheat output enable delay after power-stable, in ns
	localparam int unsigned TRIP_EN_NS       = 10000;
	localparam int unsigned TRIP_EN_CYC      = (TRIP_EN_NS * CLK_MHZ) / 1000;
	// bus outputs released within this many clocks of reset
	localparam int unsigned BUS_REL_CYC      = 2;
	localparam int unsigned SYNC_STAGES      = 2;
	localparam int unsigned CFG_W            = 8;
	localparam logic [7:0]  CFG_RESET        = 8'h00;

	typedef enum logic [1:0] {
		PSC_RUN,
		PSC_HALT,
		PSC_HANDLER
	} psc_core_t;
endpackage

// ==== common/psc_if.sv ====
// sideband signals between the processor end and the core logic end
interface psc_if;
	logic                          power_stable;
	logic                          reset_n;
	logic                          test_reset_n;
	logic                          clock_halt_request_n;
	logic                          mgmt_interrupt_n;
	logic                          priority_agent_request_n;
	logic                          lock_n_out;
	logic                          lock_n_oe;
	logic                          thermal_alert_n_dev;
	logic                          thermal_alert_n_dev_oe;
	logic                          thermal_alert_n_sys;
	logic                          thermal_alert_n_sys_oe;
	logic                          overheat_shutdown_n;
	logic                          overheat_shutdown_n_oe;
	logic                          core_supply_en;
	logic [psc_pkg::CFG_W-1:0]     cfg_bus;
	logic                          cfg_bus_oe;
	logic                          bus_out_oe;
	logic                          halt_ack;
	logic                          mgmt_ack;
	// wired-and resolution of the open-drain lines
	logic                          lock_n_line;
	logic                          thermal_alert_n_line;
	assign lock_n_line = ~(lock_n_oe & ~lock_n_out);
	assign thermal_alert_n_line = ~(thermal_alert_n_dev_oe & ~thermal_alert_n_dev)
		& ~(thermal_alert_n_sys_oe & ~thermal_alert_n_sys);

	modport dev (
		input  power_stable, reset_n, test_reset_n, clock_halt_request_n,
		input  mgmt_interrupt_n, priority_agent_request_n, cfg_bus,
		input  cfg_bus_oe, thermal_alert_n_line, lock_n_line,
		output lock_n_out, lock_n_oe, thermal_alert_n_dev,
		output thermal_alert_n_dev_oe, overheat_shutdown_n,
		output overheat_shutdown_n_oe, bus_out_oe, halt_ack, mgmt_ack
	);
	modport sys (
		output power_stable, reset_n, test_reset_n, clock_halt_request_n,
		output mgmt_interrupt_n, priority_agent_request_n, cfg_bus,
		output cfg_bus_oe, thermal_alert_n_sys, thermal_alert_n_sys_oe,
		output core_supply_en,
		input  thermal_alert_n_line, lock_n_line, overheat_shutdown_n,
		input  overheat_shutdown_n_oe, bus_out_oe, halt_ack, mgmt_ack
	);
endinterface

// ==== logic/psc_sync.sv ====
// two-flop synchroniser for asynchronous sideband inputs
module psc_sync #(
	parameter logic RESET_VAL = 1'b1
) (
	input  wire logic mclk_in,
	input  wire logic rst_in,
	input  wire logic async_in,
	output logic      sync_out
);
	logic meta_reg;
	logic sync_reg;

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			meta_reg <= RESET_VAL;
			sync_reg <= RESET_VAL;
		end else begin
			meta_reg <= async_in;
			sync_reg <= meta_reg;
		end
	end

	assign sync_out = sync_reg;
endmodule

// ==== logic/psc_device.sv ====
// processor end: reset, halt, handler, lock, thermal alert and overheat trip
// Summary of operation
// RULE1 - hold lock low across whole locked sequence
// RULE2 - priority agent waits for lock release
// RULE3 - drive thermal alert when die too hot
// RULE4 - system alert engages throttle until released
// RULE5 - power-stable held low cleanly, then monotonic
// RULE6 - keep power-stable high during boundary scan
// RULE7 - reset returns known state, drops caches unwritten
// RULE8 - power-on reset held at least 1 ms
// RULE9 - release bus outputs within two clocks
// RULE10 - reset not over 10 ms with power-stable
// RULE11 - sample configuration on reset release
// RULE12 - management interrupt: save, enter handler, ack
// RULE13 - interrupt at reset release floats outputs
// RULE14 - halt request: ack, stop core clocks, snoop
// RULE15 - halt release restarts clocks, bus clock untouched
// RULE16 - overheat trip stops internal clocks
// RULE17 - overheat output enabled within 10 us
// RULE18 - overheat latched until power-stable drops
// RULE19 - system removes core supply after overheat
// RULE20 - test reset driven low at power-on
// RULE21 - synchronise asynchronous sideband inputs twice
module psc_device #(
	parameter int unsigned TRIP_EN_CYCLES = psc_pkg::TRIP_EN_CYC
) (
	input  wire logic                       mclk_in,
	input  wire logic                       rst_in,
	psc_if.dev                              link,
	input  wire logic                       lock_seq_in,
	input  wire logic                       throttle_enable_in,
	input  wire logic                       die_hot_in,
	input  wire logic                       die_trip_in,
	input  wire logic                       handler_done_in,
	output logic                            throttle_circuit_out,
	output logic                            core_clk_en_out,
	output logic                            protected_handler_mode_out,
	output logic                            cache_invalidate_out,
	output logic [psc_pkg::CFG_W-1:0]       cfg_options_out
);
	// the enable delay counter is 12 bits wide
	if (TRIP_EN_CYCLES < 1 || TRIP_EN_CYCLES > 4095) begin : g_bad_trip
		$error("trip enable delay out of range");
	end

	logic                        halt_req_s;
	logic                        mgmt_int_s;
	logic                        sys_alert_s;
	logic                        in_reset;
	logic                        reset_d_reg;
	logic                        float_reg;
	logic [psc_pkg::CFG_W-1:0]   cfg_reg;
	logic                        inval_reg;
	psc_pkg::psc_core_t          core_reg;
	psc_pkg::psc_core_t          core_next;
	logic                        mgmt_seen_reg;
	logic                        halt_ack_reg;
	logic                        mgmt_ack_reg;
	logic                        lock_reg;
	logic                        trip_reg;
	logic                        trip_oe_reg;
	logic [11:0]                 trip_cnt_reg;
	logic                        alert_reg;
	logic                        throttle_reg;

	// RULE21 two-stage synchronisers
	psc_sync u_sync_halt (
		.mclk_in  (mclk_in),
		.rst_in   (rst_in),
		.async_in (link.clock_halt_request_n),
		.sync_out (halt_req_s)
	);
	psc_sync u_sync_mgmt (
		.mclk_in  (mclk_in),
		.rst_in   (rst_in),
		.async_in (link.mgmt_interrupt_n),
		.sync_out (mgmt_int_s)
	);
	psc_sync u_sync_alert (
		.mclk_in  (mclk_in),
		.rst_in   (rst_in),
		.async_in (link.thermal_alert_n_line),
		.sync_out (sys_alert_s)
	);

	assign in_reset = ~link.reset_n | ~link.power_stable;

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			reset_d_reg <= 1'b1;
		end else begin
			reset_d_reg <= in_reset;
		end
	end

	// RULE11 capture straps on release
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			cfg_reg <= psc_pkg::CFG_RESET;
		end else if (reset_d_reg && !in_reset) begin
			cfg_reg <= link.cfg_bus;
		end
	end

	// RULE13 float when interrupt held at release
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			float_reg <= 1'b0;
		end else if (!link.power_stable) begin
			float_reg <= 1'b0;
		end else if (reset_d_reg && !in_reset) begin
			float_reg <= ~mgmt_int_s;
		end
	end

	// RULE7 drop caches without write-back
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			inval_reg <= 1'b1;
		end else begin
			inval_reg <= in_reset;
		end
	end

	// core state; trip and reset override everything
	always_comb begin
		core_next = core_reg;
		unique case (core_reg)
			psc_pkg::PSC_RUN: begin
				if (!mgmt_int_s && !mgmt_seen_reg) begin
					core_next = psc_pkg::PSC_HANDLER;
				end else if (!halt_req_s) begin
					core_next = psc_pkg::PSC_HALT;
				end
			end
			psc_pkg::PSC_HALT: begin
				if (halt_req_s) begin
					core_next = psc_pkg::PSC_RUN;
				end
			end
			psc_pkg::PSC_HANDLER: begin
				if (handler_done_in) begin
					core_next = psc_pkg::PSC_RUN;
				end
			end
			default: core_next = psc_pkg::PSC_RUN;
		endcase
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			core_reg <= psc_pkg::PSC_RUN;
		end else if (in_reset) begin
			core_reg <= psc_pkg::PSC_RUN;
		end else if (!trip_reg) begin
			core_reg <= core_next;
		end
	end

	// level input: one entry per assertion
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			mgmt_seen_reg <= 1'b0;
		end else if (in_reset || mgmt_int_s) begin
			mgmt_seen_reg <= 1'b0;
		end else if (core_reg == psc_pkg::PSC_HANDLER) begin
			mgmt_seen_reg <= 1'b1;
		end
	end

	// RULE12 handler entry ack
	// RULE14 halt-grant ack
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			halt_ack_reg <= 1'b0;
			mgmt_ack_reg <= 1'b0;
		end else begin
			halt_ack_reg <= !in_reset && !trip_reg
				&& core_reg == psc_pkg::PSC_RUN
				&& core_next == psc_pkg::PSC_HALT;
			mgmt_ack_reg <= !in_reset && !trip_reg
				&& core_reg == psc_pkg::PSC_RUN
				&& core_next == psc_pkg::PSC_HANDLER;
		end
	end

	// RULE1 lock held over the whole sequence
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			lock_reg <= 1'b0;
		end else begin
			lock_reg <= lock_seq_in && !in_reset;
		end
	end

	// RULE17 overheat driver enable delay
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			trip_cnt_reg <= 12'h000;
			trip_oe_reg  <= 1'b0;
		end else if (!link.power_stable) begin
			trip_cnt_reg <= 12'h000;
			trip_oe_reg  <= 1'b0;
		end else if (trip_cnt_reg == 12'(TRIP_EN_CYCLES - 1)) begin
			trip_oe_reg  <= 1'b1;
		end else begin
			trip_cnt_reg <= trip_cnt_reg + 12'h001;
		end
	end

	// RULE18 latched until power-stable drops
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			trip_reg <= 1'b0;
		end else if (!link.power_stable) begin
			trip_reg <= 1'b0;
		end else if (trip_oe_reg && die_trip_in) begin
			trip_reg <= 1'b1;
		end
	end

	// RULE3 own alert from on-die monitor
	// RULE4 system alert engages throttle
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			alert_reg    <= 1'b0;
			throttle_reg <= 1'b0;
		end else begin
			alert_reg    <= die_hot_in && link.power_stable;
			// masking our own drive with an unsynced flag let throttle
			// drop out for a cycle; the echo of our own alert only
			// stretches throttling by the alert register plus the synchroniser depth, three cycles
			throttle_reg <= throttle_enable_in
				&& (die_hot_in || !sys_alert_s);
		end
	end

	// RULE9 release bus outputs in reset
	// stay off in the release cycle until the float decision is made
	assign link.bus_out_oe = !in_reset && !reset_d_reg && !float_reg;
	assign link.lock_n_out = 1'b0;
	assign link.lock_n_oe  = lock_reg && !in_reset && !reset_d_reg
		&& !float_reg;
	assign link.thermal_alert_n_dev    = 1'b0;
	assign link.thermal_alert_n_dev_oe = alert_reg;
	assign link.overheat_shutdown_n    = ~trip_reg;
	assign link.overheat_shutdown_n_oe = trip_oe_reg;
	assign link.halt_ack = halt_ack_reg;
	assign link.mgmt_ack = mgmt_ack_reg;

	// RULE16 trip stops core clocks
	// RULE15 halt only gates core clocks
	assign core_clk_en_out = !trip_reg && !in_reset
		&& core_reg != psc_pkg::PSC_HALT;
	assign throttle_circuit_out       = throttle_reg;
	assign protected_handler_mode_out = core_reg == psc_pkg::PSC_HANDLER;
	assign cache_invalidate_out       = inval_reg;
	assign cfg_options_out            = cfg_reg;
endmodule

// ==== logic/psc_system.sv ====
// core logic end: power-stable, reset timing, sideband requests
module psc_system #(
	parameter int unsigned POR_CYCLES = psc_pkg::POR_HOLD_CYC
) (
	input  wire logic                  mclk_in,
	input  wire logic                  rst_in,
	psc_if.sys                         link,
	input  wire logic                  supplies_ok_in,
	input  wire logic                  warm_reset_req_in,
	input  wire logic                  halt_req_in,
	input  wire logic                  mgmt_req_in,
	input  wire logic                  sys_hot_in,
	input  wire logic                  bus_priority_req_in,
	input  wire logic [psc_pkg::CFG_W-1:0] cfg_straps_in,
	output logic                       bus_granted_out,
	output logic                       overheat_seen_out
);
	// RULE10 warm reset reuses this count, so it must stay short
	if (POR_CYCLES < 1 || POR_CYCLES >= psc_pkg::RST_MAX_CYC)
	begin : g_bad_por
		$error("power-on reset count out of range");
	end

	logic        pwr_reg;
	logic        rst_n_reg;
	logic [31:0] rst_cnt_reg;
	logic        trip_reg;
	logic        warm_reg;

	// RULE5 clean monotonic power-stable
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			pwr_reg <= 1'b0;
		end else begin
			pwr_reg <= supplies_ok_in && !trip_reg;
		end
	end

	// RULE19 latch overheat, cut core supply
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			trip_reg <= 1'b0;
		end else if (!supplies_ok_in) begin
			trip_reg <= 1'b0;
		end else if (link.overheat_shutdown_n_oe
			&& !link.overheat_shutdown_n) begin
			trip_reg <= 1'b1;
		end
	end

	// RULE8 hold reset for the power-on time
	// RULE10 warm reset stays far below limit
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			rst_cnt_reg <= 32'h0000_0000;
			rst_n_reg   <= 1'b0;
			warm_reg    <= 1'b0;
		end else if (!pwr_reg) begin
			rst_cnt_reg <= 32'h0000_0000;
			rst_n_reg   <= 1'b0;
			warm_reg    <= 1'b0;
		end else if (!rst_n_reg) begin
			if (rst_cnt_reg >= 32'(POR_CYCLES - 1)) begin
				rst_n_reg <= 1'b1;
			end else begin
				rst_cnt_reg <= rst_cnt_reg + 32'h0000_0001;
			end
		end else if (warm_reset_req_in && !warm_reg) begin
			rst_n_reg   <= 1'b0;
			rst_cnt_reg <= 32'h0000_0000;
			warm_reg    <= 1'b1;
		end else if (!warm_reset_req_in) begin
			warm_reg <= 1'b0;
		end
	end

	// RULE2 priority agent waits for lock release
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			bus_granted_out <= 1'b0;
		end else begin
			bus_granted_out <= bus_priority_req_in && link.lock_n_line
				&& rst_n_reg;
		end
	end

	// RULE6 power-stable never dropped by scan
	assign link.power_stable = pwr_reg;
	assign link.reset_n      = rst_n_reg;
	// RULE20 test reset low through power-on
	assign link.test_reset_n = rst_n_reg;
	assign link.core_supply_en = supplies_ok_in && !trip_reg;
	assign link.clock_halt_request_n     = ~halt_req_in;
	assign link.mgmt_interrupt_n         = ~mgmt_req_in;
	assign link.priority_agent_request_n = ~bus_priority_req_in;
	// RULE4 system-side alert drive
	assign link.thermal_alert_n_sys    = 1'b0;
	assign link.thermal_alert_n_sys_oe = sys_hot_in;
	// RULE11 straps driven only while reset
	assign link.cfg_bus    = cfg_straps_in;
	assign link.cfg_bus_oe = ~rst_n_reg;
	assign overheat_seen_out = trip_reg;
endmodule

// ==== bench/psc_link_asserts.sv ====
// checker on the sideband link between processor and core logic
module psc_link_asserts #(
	parameter int unsigned POR_CYCLES = psc_pkg::POR_HOLD_CYC
) (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic power_stable,
	input wire logic reset_n,
	input wire logic test_reset_n,
	input wire logic clock_halt_request_n,
	input wire logic mgmt_interrupt_n,
	input wire logic lock_n_oe,
	input wire logic overheat_shutdown_n,
	input wire logic overheat_shutdown_n_oe,
	input wire logic core_supply_en,
	input wire logic bus_out_oe,
	input wire logic halt_ack,
	input wire logic mgmt_ack
);
	localparam int TRIP_MAX = int'(psc_pkg::TRIP_EN_CYC);
	logic [15:0] low_cnt_reg;
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (rst_in);

	// saturates so a long reset never wraps to a short count
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			low_cnt_reg <= 16'h0000;
		end else if (reset_n) begin
			low_cnt_reg <= 16'h0000;
		end else if (low_cnt_reg != 16'hffff) begin
			low_cnt_reg <= low_cnt_reg + 16'h0001;
		end
	end

	property p_bus_release;
		$fell(reset_n) |-> ##[0:2] (!bus_out_oe && !lock_n_oe);
	endproperty
	a_bus_release: assert property (p_bus_release)
		else $error("bus outputs still driven after reset");
	property p_halt_sync;
		halt_ack |-> !$past(clock_halt_request_n, 2) ##1 !halt_ack;
	endproperty
	a_halt_sync: assert property (p_halt_sync)
		else $error("halt acknowledge without synced request");
	property p_mgmt_sync;
		mgmt_ack |-> !$past(mgmt_interrupt_n, 2) ##1 !mgmt_ack;
	endproperty
	a_mgmt_sync: assert property (p_mgmt_sync)
		else $error("handler acknowledge without synced request");
	property p_float;
		(!mgmt_interrupt_n)[*4] ##0 $rose(reset_n) |-> (!bus_out_oe)[*8];
	endproperty
	a_float: assert property (p_float)
		else $error("outputs driven after release with interrupt low");
	property p_trip_en;
		$rose(power_stable) |->
			##[1:TRIP_MAX] (overheat_shutdown_n_oe || !power_stable);
	endproperty
	a_trip_en: assert property (p_trip_en)
		else $error("overheat output not enabled in time");
	property p_trip_off;
		!power_stable |=> !overheat_shutdown_n_oe;
	endproperty
	a_trip_off: assert property (p_trip_off)
		else $error("overheat output enabled without power stable");
	property p_trip_latch;
		overheat_shutdown_n_oe && !overheat_shutdown_n && power_stable
			|=> (!overheat_shutdown_n || !power_stable);
	endproperty
	a_trip_latch: assert property (p_trip_latch)
		else $error("overheat output cleared while power stable");
	property p_supply_off;
		overheat_shutdown_n_oe && !overheat_shutdown_n
			|-> ##[1:2] (!core_supply_en && !power_stable);
	endproperty
	a_supply_off: assert property (p_supply_off)
		else $error("core supply kept after overheat");
	property p_test_reset;
		!power_stable |=> !test_reset_n;
	endproperty
	a_test_reset: assert property (p_test_reset)
		else $error("test reset high during power-on");
	property p_por;
		$rose(reset_n) |-> low_cnt_reg >= POR_CYCLES - 1;
	endproperty
	a_por: assert property (p_por)
		else $error("reset released too early");

	c_halt: cover property (halt_ack);
	c_mgmt: cover property (mgmt_ack);
	c_float: cover property (!mgmt_interrupt_n && $rose(reset_n));
	c_trip: cover property (overheat_shutdown_n_oe && !overheat_shutdown_n);
endmodule

// ==== bench/tb.sv ====
// self-checking bench joining both ends of the sideband link
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic       mclk_in = 1'b0;
	logic       rst_in = 1'b1;
	logic       lock_seq = 1'b0, thr_en = 1'b0, die_hot = 1'b0;
	logic       die_trip = 1'b0, h_done = 1'b0, sup_ok = 1'b1;
	logic       warm = 1'b0, halt_req = 1'b0, mgmt_req = 1'b0;
	logic       sys_hot = 1'b0, prio_req = 1'b0;
	logic [7:0] straps = 8'h00;
	logic       throttle, clk_en, hmode, cinv, granted, ohs;
	logic [7:0] cfg;
	int         errors = 0;
	int         num_checks = 0;

	psc_if link ();
	always #20 mclk_in = ~mclk_in;

	psc_device #(.TRIP_EN_CYCLES(4)) i_psc_device (
		.mclk_in(mclk_in), .rst_in(rst_in), .link(link),
		.lock_seq_in(lock_seq), .throttle_enable_in(thr_en),
		.die_hot_in(die_hot), .die_trip_in(die_trip),
		.handler_done_in(h_done), .throttle_circuit_out(throttle),
		.core_clk_en_out(clk_en), .protected_handler_mode_out(hmode),
		.cache_invalidate_out(cinv), .cfg_options_out(cfg));
	psc_system #(.POR_CYCLES(8)) i_psc_system (
		.mclk_in(mclk_in), .rst_in(rst_in), .link(link),
		.supplies_ok_in(sup_ok), .warm_reset_req_in(warm),
		.halt_req_in(halt_req), .mgmt_req_in(mgmt_req),
		.sys_hot_in(sys_hot), .bus_priority_req_in(prio_req),
		.cfg_straps_in(straps), .bus_granted_out(granted),
		.overheat_seen_out(ohs));
	psc_link_asserts #(.POR_CYCLES(8)) i_psc_link_asserts (
		.mclk_in(mclk_in), .rst_in(rst_in),
		.power_stable(link.power_stable), .reset_n(link.reset_n),
		.test_reset_n(link.test_reset_n),
		.clock_halt_request_n(link.clock_halt_request_n),
		.mgmt_interrupt_n(link.mgmt_interrupt_n),
		.lock_n_oe(link.lock_n_oe),
		.overheat_shutdown_n(link.overheat_shutdown_n),
		.overheat_shutdown_n_oe(link.overheat_shutdown_n_oe),
		.core_supply_en(link.core_supply_en),
		.bus_out_oe(link.bus_out_oe), .halt_ack(link.halt_ack),
		.mgmt_ack(link.mgmt_ack));

	task automatic report_and_stop();
		if (errors == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk_in);
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	function automatic logic exp_thr(input logic en, input logic hot);
		return en & hot;
	endfunction
	function automatic logic pick(input int s);
		case (s)
			0: return link.reset_n;
			1: return link.halt_ack;
			2: return link.mgmt_ack;
			default: return ohs;
		endcase
	endfunction
	// polls off the edge so a one-cycle pulse is not missed
	task automatic wait_for(input int s, input logic v);
		int k;
		for (k = 0; k < 200; k++) begin
			@(posedge mclk_in);
			#5;
			if (pick(s) === v) break;
		end
		chk(pick(s), v);
		@(posedge mclk_in);
	endtask
	task automatic warm_reset(input logic [7:0] s, input logic oe);
		straps <= s;
		warm <= 1'b1;
		wait_for(0, 1'b0);
		#5 chk(link.bus_out_oe, 1'b0);
		chk(cinv, 1'b1);
		cyc(1);
		warm <= 1'b0;
		wait_for(0, 1'b1);
		cyc(2);
		#5 chk(cfg, s);
		chk(link.bus_out_oe, oe);
		chk(cinv, 1'b0);
		cyc(1);
	endtask

	initial begin
		repeat (4000) @(posedge mclk_in);
		errors++;
		report_and_stop();
	end

	initial begin
		void'($urandom(22));
		cyc(6);
		rst_in <= 1'b0;
		straps <= 8'($urandom);
		wait_for(0, 1'b1);
		cyc(2);
		#5 chk(cfg, straps);
		chk(cinv, 1'b0);
		cyc(1);
		lock_seq <= 1'b1;
		prio_req <= 1'b1;
		cyc(4 + $urandom % 4);
		#5 chk(link.lock_n_line, 1'b0);
		chk(granted, 1'b0);
		cyc(1);
		lock_seq <= 1'b0;
		cyc(4);
		#5 chk(granted, 1'b1);
		cyc(1);
		prio_req <= 1'b0;
		for (int e = 0; e < 2; e++) begin
			thr_en <= e[0];
			die_hot <= 1'b1;
			cyc(3);
			#5 chk(link.thermal_alert_n_line, 1'b0);
			chk(throttle, exp_thr(e[0], 1'b1));
			cyc(1);
			die_hot <= 1'b0;
			sys_hot <= 1'b1;
			cyc(5);
			#5 chk(throttle, exp_thr(e[0], 1'b1));
			cyc(1);
			sys_hot <= 1'b0;
			cyc(5);
			#5 chk(throttle, 1'b0);
			cyc(1);
		end
		halt_req <= 1'b1;
		wait_for(1, 1'b1);
		#5 chk(clk_en, 1'b0);
		cyc(1);
		halt_req <= 1'b0;
		cyc(5);
		#5 chk(clk_en, 1'b1);
		cyc(1);
		mgmt_req <= 1'b1;
		wait_for(2, 1'b1);
		#5 chk(hmode, 1'b1);
		cyc(1);
		mgmt_req <= 1'b0;
		cyc(3);
		h_done <= 1'b1;
		cyc(1);
		h_done <= 1'b0;
		cyc(3);
		#5 chk(hmode, 1'b0);
		cyc(1);
		for (int n = 0; n < 4; n++) begin
			warm_reset(8'($urandom), 1'b1);
		end
		mgmt_req <= 1'b1;
		cyc(4);
		warm_reset(8'hc3, 1'b0);
		mgmt_req <= 1'b0;
		cyc(3);
		h_done <= 1'b1;
		cyc(1);
		h_done <= 1'b0;
		warm_reset(8'h3c, 1'b1);
		die_trip <= 1'b1;
		wait_for(3, 1'b1);
		#5 chk(clk_en, 1'b0);
		chk(link.core_supply_en, 1'b0);
		chk(link.power_stable, 1'b0);
		report_and_stop();
	end
endmodule
